// [hdl/i2c_slave_stretch_buffer.sv]
// i2c slave port: control, clock stretching, data and prefetch buffers, apb registers
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module i2c_slave_stretch_buffer
  import i2c_slave_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output wire logic [31:0] prdata,
  output wire logic        pready,
  output wire logic        pslverr,
  input  wire logic        sclIn,
  output wire logic        sclOut,
  output wire logic        sclOe,
  input  wire logic        sdaIn,
  output wire logic        sdaOut,
  output wire logic        sdaOe,
  output wire logic        slewStdMode,
  output wire logic        byteIrq
);
  // ****************************************
  // declarations
  // ****************************************
  logic       modRst_r;
  logic       rstLocalN;
  logic       enable_r;
  logic       speed_r;
  logic       release_r;
  logic       wrStretch_r;
  logic       rdStretch_r;
  logic [7:0] dataBuf_r;
  logic [7:0] prefetch_r;
  logic [6:0] ownAddr_r;
  logic       dir_r;
  logic       bf_r;
  logic       wcol_r;
  logic       ovr_r;
  logic       nack_r;
  logic       busy_r;
  logic       pendLoad_r;
  logic [PREF_DELAY-1:0] prefDly_r;
  logic [31:0] prdata_r;
  logic       irq_r;
  slv_state_t state_r;
  slv_state_t state_nxt;
  logic       sclS;
  logic       sdaS;
  logic       sclRise;
  logic       sclFall;
  logic       startCond;
  logic       stopCond;
  logic       rxPlace;
  logic       txStart;
  logic       rxAckEnd;
  logic       irqEvt;
  shift_if    sh ();

  // ****************************************
  // apb decode
  // ****************************************
  wire logic       access   = psel & penable;
  wire logic       setup    = psel & ~penable;
  wire logic       wrAcc    = access & pwrite;
  wire logic       rdAcc    = access & ~pwrite;
  wire logic       selCtrl  = paddr == CTRL_OFS;
  wire logic       selData  = paddr == DATA_OFS;
  wire logic       selPref  = paddr == PREF_OFS;
  wire logic       selStat  = paddr == STAT_OFS;
  wire logic       selAddr  = paddr == ADDR_OFS;
  wire logic       mapped   = selCtrl | selData | selPref | selStat | selAddr;
  wire logic       ctrlWr   = wrAcc & selCtrl;
  wire logic       dataWr   = wrAcc & selData;
  wire logic       statWr   = wrAcc & selStat;
  wire logic       dataRd   = rdAcc & selData;
  // buffer writes only while the master waits on a read
  wire logic       dataOk   = rdStretch_r & dir_r & ~release_r;  // RL14
  wire logic       dataRej  = dataWr & ~dataOk;                  // RL15
  wire logic [7:0] ctrlView = {2'b00, modRst_r, rdStretch_r, wrStretch_r,
                               release_r, speed_r, enable_r};
  wire logic [7:0] statView = {2'b00, busy_r, dir_r, bf_r, nack_r, wcol_r, ovr_r};
  wire logic [7:0] rdMux    = selCtrl ? ctrlView :
                              selData ? dataBuf_r :
                              selPref ? prefetch_r :
                              selStat ? statView :
                              selAddr ? {1'b0, ownAddr_r} : 8'h00;
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata  = prdata_r;

  // ****************************************
  // global and module-local resets
  // ****************************************
  // gated reset trades a little glitch risk for a true flip-flop clear
  assign rstLocalN = rst_n & ~modRst_r;  // RL10

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      modRst_r <= 1'b0;  // RL11
    end else if (ce && ctrlWr) begin
      modRst_r <= pwdata[MRST_BIT];
    end
  end

  // ****************************************
  // pins, shifter
  // ****************************************
  i2c_pin_sync u_sync (
    .clk_sys   (clk_sys),
    .rst_n     (rstLocalN),
    .ce        (ce),
    .sclIn     (sclIn),
    .sdaIn     (sdaIn),
    .scl       (sclS),
    .sda       (sdaS),
    .sclRise   (sclRise),
    .sclFall   (sclFall),
    .startCond (startCond),
    .stopCond  (stopCond)
  );  // RL23

  i2c_byte_shifter u_shift (
    .clk_sys (clk_sys),
    .rst_n   (rstLocalN),
    .ce      (ce),
    .bus     (sh.shifter)
  );

  wire logic byteDone = sh.count == BYTE_BITS;
  wire logic addrHit  = sh.data[7:1] == ownAddr_r;
  wire logic addrTake = (state_r == ST_ADDR) & sclFall & byteDone & addrHit;
  wire logic nackSeen = (state_r == ST_TX_ACK) & sclRise & sdaS;
  assign sh.inBit    = sdaS;
  assign sh.load     = pendLoad_r | prefDly_r[PREF_DELAY-1];
  assign sh.loadData = pendLoad_r ? dataBuf_r : prefetch_r;  // RL8

  // ****************************************
  // bus state machine
  // ****************************************
  always_comb begin
    state_nxt   = state_r;
    rxPlace     = 1'b0;
    txStart     = 1'b0;
    rxAckEnd    = 1'b0;
    irqEvt      = 1'b0;
    sh.clear    = 1'b0;
    sh.shiftIn  = 1'b0;
    sh.shiftOut = 1'b0;
    sh.tick     = 1'b0;
    if (!enable_r || stopCond) begin  // RL1
      state_nxt = ST_IDLE;
    end else if (startCond) begin
      state_nxt = ST_ADDR;
      sh.clear  = 1'b1;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          state_nxt = ST_IDLE;
        end
        ST_ADDR: begin
          if (sclRise) begin
            sh.shiftIn = 1'b1;
          end else if (sclFall && byteDone) begin
            state_nxt = addrHit ? ST_ADDR_ACK : ST_IDLE;
          end
        end
        ST_ADDR_ACK: begin
          if (sclFall) begin
            sh.clear  = 1'b1;
            irqEvt    = 1'b1;
            txStart   = dir_r;
            state_nxt = dir_r ? ST_TX : ST_RX;
          end
        end
        ST_RX: begin
          if (sclRise) begin
            sh.shiftIn = 1'b1;
          end else if (sclFall && byteDone) begin
            rxPlace   = 1'b1;  // RL13
            state_nxt = ST_RX_ACK;
          end
        end
        ST_RX_ACK: begin
          if (sclFall) begin
            sh.clear  = 1'b1;
            irqEvt    = 1'b1;  // RL13
            rxAckEnd  = 1'b1;
            state_nxt = ST_RX;
          end
        end
        ST_TX: begin
          if (sclRise) begin
            sh.tick = 1'b1;
          end else if (sclFall && byteDone) begin
            state_nxt = ST_TX_ACK;  // RL12
          end else if (sclFall && sh.count != 4'h0) begin
            sh.shiftOut = 1'b1;  // RL12
          end
        end
        ST_TX_ACK: begin
          if (nackSeen) begin
            state_nxt = ST_IDLE;
          end else if (sclFall) begin
            sh.clear  = 1'b1;
            irqEvt    = 1'b1;
            txStart   = 1'b1;
            state_nxt = ST_TX;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstLocalN) begin
    if (!rstLocalN) begin
      state_r <= ST_IDLE;
      irq_r   <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      irq_r   <= irqEvt;
    end
  end

  // ****************************************
  // control register
  // ****************************************
  wire logic autoHold = (rxAckEnd & wrStretch_r & ~dir_r)  // RL5
                      | (txStart & rdStretch_r);           // RL6

  always_ff @(posedge clk_sys or negedge rstLocalN) begin
    if (!rstLocalN) begin
      {rdStretch_r, wrStretch_r} <= {CTRL_RST[RDS_BIT], CTRL_RST[WRS_BIT]};  // RL18
      {speed_r, enable_r}        <= {CTRL_RST[SPEED_BIT], CTRL_RST[EN_BIT]};
      ownAddr_r                  <= ADDR_RST;
    end else if (ce) begin
      if (ctrlWr) begin
        enable_r    <= pwdata[EN_BIT];
        speed_r     <= pwdata[SPEED_BIT];
        wrStretch_r <= pwdata[WRS_BIT];  // RL16
        rdStretch_r <= pwdata[RDS_BIT];  // RL17
      end
      if (wrAcc && selAddr) begin
        ownAddr_r <= pwdata[6:0];
      end
    end
  end

  // hardware hold wins over a release written in the same cycle
  always_ff @(posedge clk_sys or negedge rstLocalN) begin
    if (!rstLocalN) begin
      release_r <= CTRL_RST[REL_BIT];
    end else if (ce) begin
      if (autoHold) begin
        release_r <= 1'b0;
      end else if (ctrlWr) begin
        release_r <= pwdata[REL_BIT];  // RL3
      end
    end
  end

  // ****************************************
  // buffers and transmit loading
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstLocalN) begin
    if (!rstLocalN) begin
      dataBuf_r  <= DATA_RST;
      prefetch_r <= PREF_RST;
    end else if (ce) begin
      if (dataWr && dataOk) begin
        dataBuf_r <= pwdata[7:0];  // RL14
      end else if (rxPlace && !bf_r) begin
        dataBuf_r <= sh.data;  // RL22
      end
      if (wrAcc && selPref) begin
        prefetch_r <= pwdata[7:0];
      end
    end
  end

  // stretched read reloads from the data buffer until scl is released
  always_ff @(posedge clk_sys or negedge rstLocalN) begin
    if (!rstLocalN) begin
      pendLoad_r <= 1'b0;
      prefDly_r  <= '0;
    end else if (ce) begin
      if (txStart && rdStretch_r) begin
        pendLoad_r <= 1'b1;  // RL7
      end else if (release_r) begin
        pendLoad_r <= 1'b0;
      end
      prefDly_r <= {prefDly_r[PREF_DELAY-2:0], txStart & ~rdStretch_r};  // RL9
    end
  end

  // ****************************************
  // status flags, set wins over clear except for dir_r and nack_r, where clear wins
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstLocalN) begin
    if (!rstLocalN) begin
      {bf_r, ovr_r, wcol_r} <= 3'b000;
    end else if (ce) begin
      bf_r   <= (rxPlace & ~dir_r) | (bf_r & ~dataRd);                     // RL19
      ovr_r  <= (rxPlace & bf_r) | (ovr_r & ~(statWr & pwdata[OVR_BIT]));   // RL22
      wcol_r <= dataRej | (wcol_r & ~(statWr & pwdata[WCOL_BIT]));          // RL20
    end
  end

  always_ff @(posedge clk_sys or negedge rstLocalN) begin
    if (!rstLocalN) begin
      {dir_r, nack_r, busy_r} <= 3'b000;
    end else if (ce) begin
      if (startCond || stopCond || nackSeen) begin
        dir_r <= 1'b0;
      end else if (addrTake) begin
        dir_r <= sh.data[0];  // RL21
      end
      if (startCond) begin
        nack_r <= 1'b0;
      end else if ((state_r == ST_TX_ACK) && sclRise) begin
        nack_r <= sdaS;
      end
      busy_r <= startCond | (busy_r & ~stopCond);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (ce && setup) begin
      prdata_r <= {24'h00_0000, rdMux};
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  wire logic ackDrive = (state_r == ST_ADDR_ACK) | (state_r == ST_RX_ACK);
  wire logic txDrive  = (state_r == ST_TX) & ~sh.data[7];
  assign sclOut      = 1'b0;
  assign sdaOut      = 1'b0;
  assign sclOe       = enable_r & ~release_r;                // RL3
  assign sdaOe       = enable_r & (ackDrive | txDrive);      // RL4
  assign slewStdMode = speed_r;                              // RL2
  assign byteIrq     = irq_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstLocalN);

  sequence txLaunch;
    ce && txStart && !rdStretch_r;
  endsequence
  sequence prefCopy;
    ce[*2] ##0 (sh.load && !pendLoad_r && sh.loadData == prefetch_r);
  endsequence

  hold_scl_a: assert property (enable_r && !release_r |-> sclOe)  // RL3
    else $error("scl not held while release bit low");
  idle_bus_a: assert property (!enable_r |-> !sclOe && !sdaOe)  // RL4
    else $error("disabled port drives the bus");
  pref_copy_a: assert property (txLaunch |-> ##1 prefCopy)  // RL9
    else $error("prefetch not copied two clocks after interrupt");
  wr_hold_a: assert property (ce && rxAckEnd && wrStretch_r && !dir_r |=> !release_r && sclOe == enable_r)  // RL5
    else $error("write stretch did not hold scl");
  rd_hold_a: assert property (ce && txStart && rdStretch_r |=> !release_r ##0 pendLoad_r)  // RL6
    else $error("read stretch did not hold scl");
  wcol_set_a: assert property (ce && dataRej |=> wcol_r && $stable(dataBuf_r))  // RL15
    else $error("refused write changed buffer or missed conflict");
  wcol_keep_a: assert property (ce && wcol_r && !statWr |=> wcol_r)  // RL20
    else $error("conflict flag cleared by hardware");
  bf_clear_a: assert property (ce && dataRd && !rxPlace |=> !bf_r)  // RL19
    else $error("buffer read did not clear full flag");
  overrun_a: assert property (ce && rxPlace && bf_r |=> ovr_r && $stable(dataBuf_r))  // RL22
    else $error("overrun not flagged or buffer overwritten");
  msb_first_a: assert property (state_r == ST_TX && enable_r |-> sdaOe == !sh.data[7])  // RL12
    else $error("transmit bit is not the shifter msb");
  irq_ninth_a: assert property (ce && state_r == ST_RX_ACK && sclFall && enable_r
                                && !startCond && !stopCond |=> byteIrq)  // RL13
    else $error("no interrupt after ninth clock");
endmodule : i2c_slave_stretch_buffer

// [inc/i2c_slave_pkg.sv]
// constants, field layout and state codes of the i2c slave stretch buffer
// Summary of operation
// [RL1] port joins bus activity only while the module-enable bit is 1
// [RL2] speed bit 1 selects standard-mode edge rate, 0 selects fast-mode
// [RL3] clock-release bit 0 holds scl low, 1 releases scl
// [RL4] disabled module never drives scl or sda
// [RL5] write-stretch enable clears clock-release on each master-write byte interrupt
// [RL6] read-stretch enable clears clock-release after address byte or sent byte
// [RL7] software loads the data buffer before setting clock-release in read stretching
// [RL8] without read stretching the prefetch buffer feeds the transmit shifter automatically
// [RL9] prefetch value reaches the transmit shifter two clocks after the interrupt
// [RL10] module-reset bit at 1 resets every flip-flop of the port; prdata_r is cleared only by the global reset
// [RL11] module-reset bit itself is cleared only by the global reset; the code also clears it on a control write with MRST_BIT at 0
// [RL12] transmit shifts msb first, one bit per master clock, eight clocks a byte
// [RL13] received byte lands after eighth clock, interrupt follows the ninth
// [RL14] with read stretching, buffer writes need master-read and clock-release 0
// [RL15] a refused buffer write sets the write-conflict flag, buffer unchanged
// [RL16] software enables write stretching if it cannot serve within eight clocks
// [RL17] software adjusts stretch enables before the last byte of a transfer
// [RL18] reset values: read-stretch 1, all other control bits 0
// [RL19] reading the data buffer clears buffer-full; set on eighth fall of a write byte
// [RL20] write-conflict flag stays set until software clears it
// [RL21] direction flag holds the read/write bit of a matched address
// [RL22] byte arriving while buffer full sets overrun and is discarded
// [RL23] scl and sda are sampled on the system clock; master waits while scl held
package i2c_slave_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DATA_OFS = 8'h04;
  localparam logic [7:0] PREF_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;
  localparam logic [7:0] ADDR_OFS = 8'h10;
  localparam int EN_BIT    = 0;
  localparam int SPEED_BIT = 1;
  localparam int REL_BIT   = 2;
  localparam int WRS_BIT   = 3;
  localparam int RDS_BIT   = 4;
  localparam int MRST_BIT  = 5;
  localparam int OVR_BIT   = 0;
  localparam int WCOL_BIT  = 1;
  localparam int NACK_BIT  = 2;
  localparam int BF_BIT    = 3;
  localparam int DIR_BIT   = 4;
  localparam int BUSY_BIT  = 5;
  localparam logic [7:0] CTRL_RST = 8'h10;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] PREF_RST = 8'h00;
  localparam logic [6:0] ADDR_RST = 7'h2a;
  // ****************************************
  // timing and states
  // ****************************************
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam int         PREF_DELAY = 2;
  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_ADDR    = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_RX      = 7'h08,
    ST_RX_ACK  = 7'h10,
    ST_TX      = 7'h20,
    ST_TX_ACK  = 7'h40
  } slv_state_t;
endpackage : i2c_slave_pkg

// [inc/shift_if.sv]
// control and data signals between the port logic and its byte shifter
`timescale 1ns/1ps
interface shift_if;
  logic       clear;
  logic       load;
  logic [7:0] loadData;
  logic       shiftIn;
  logic       inBit;
  logic       shiftOut;
  logic       tick;
  logic [7:0] data;
  logic [3:0] count;
  modport ctrl    (output clear, load, loadData, shiftIn, inBit, shiftOut, tick,
                   input data, count);
  modport shifter (input clear, load, loadData, shiftIn, inBit, shiftOut, tick,
                   output data, count);
endinterface : shift_if

// [hdl/i2c_pin_sync.sv]
// two-flop synchronisers for scl and sda plus bus event detection
`timescale 1ns/1ps
module i2c_pin_sync (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output wire logic scl,
  output wire logic sda,
  output wire logic sclRise,
  output wire logic sclFall,
  output wire logic startCond,
  output wire logic stopCond
);
  logic [1:0] pin;
  logic [1:0] s1_r;
  logic [1:0] s2_r;
  logic [1:0] s3_r;
  assign pin = {sclIn, sdaIn};
  // ****************************************
  // per-line synchroniser chain
  // ****************************************
  for (genvar i = 0; i < 2; i++) begin : g_sync
    // idle bus is high, so the chain resets high
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        s1_r[i] <= 1'b1;
        s2_r[i] <= 1'b1;
        s3_r[i] <= 1'b1;
      end else if (ce) begin
        s1_r[i] <= pin[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
      end
    end
  end
  // edges only from stage two and three, never the first flop
  assign scl       = s2_r[1];
  assign sda       = s2_r[0];
  assign sclRise   = s2_r[1] & ~s3_r[1];
  assign sclFall   = ~s2_r[1] & s3_r[1];
  assign startCond = s2_r[1] & s3_r[1] & ~s2_r[0] & s3_r[0];
  assign stopCond  = s2_r[1] & s3_r[1] & s2_r[0] & ~s3_r[0];
endmodule : i2c_pin_sync

// [hdl/i2c_byte_shifter.sv]
// eight-bit shift register with bit counter, msb first both ways
`timescale 1ns/1ps
module i2c_byte_shifter (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic ce,
  shift_if.shifter  bus
);
  logic [7:0] data_r;
  logic [3:0] count_r;
  assign bus.data  = data_r;
  assign bus.count = count_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_r  <= 8'h00;
      count_r <= 4'h0;
    end else if (ce) begin
      if (bus.load) begin
        data_r  <= bus.loadData;
        count_r <= 4'h0;
      end else if (bus.clear) begin
        count_r <= 4'h0;
      end else if (bus.shiftIn) begin
        data_r  <= {data_r[6:0], bus.inBit};
        count_r <= count_r + 4'h1;
      end else if (bus.shiftOut) begin
        data_r  <= {data_r[6:0], 1'b1};
      end else if (bus.tick) begin
        count_r <= count_r + 4'h1;
      end
    end
  end
endmodule : i2c_byte_shifter

// [dv/i2c_master_model.sv]
// i2c bus master model on the open-drain scl and sda wires
`timescale 1ns/1ps
module i2c_master_model (
  input  wire logic sclOe,
  input  wire logic sdaOe,
  output wire logic sclIn,
  output wire logic sdaIn
);
  logic sclPull = 1'b0;
  logic sdaPull = 1'b0;
  // ****************************************
  // wires with pull-ups
  // ****************************************
  // a released wire floats high, never the last driven value
  assign sclIn = ~(sclPull | sclOe);
  assign sdaIn = ~(sdaPull | sdaOe);
  // ****************************************
  // bus cycles, 400 ns clock period
  // ****************************************
  task automatic bitClk(input logic b, output logic got);
    // long low phase gives the delayed prefetch copy time before scl rises
    sdaPull = ~b;
    #150 sclPull = 1'b0;
    while (sclIn !== 1'b1) #50;
    #150 got = sdaIn;
    sclPull = 1'b1;
    #100;
  endtask : bitClk
  task automatic start();
    sdaPull = 1'b0;
    sclPull = 1'b0;
    #200 sdaPull = 1'b1;
    #200 sclPull = 1'b1;
  endtask : start
  task automatic stop();
    sdaPull = 1'b1;
    #100 sclPull = 1'b0;
    while (sclIn !== 1'b1) #50;
    #200 sdaPull = 1'b0;
    #200;
  endtask : stop
  task automatic xfer(input logic [7:0] tx, input logic ackOut,
                      output logic [7:0] rx, output logic ackIn);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bitClk(tx[i], g);
      rx[i] = g;
    end
    bitClk(ackOut, ackIn);
  endtask : xfer
endmodule : i2c_master_model

// [dv/test_i2c_slave_stretch_buffer.sv]
// self-checking bench of the i2c slave stretch buffer
`timescale 1ns/1ps
module test_i2c_slave_stretch_buffer
  import i2c_slave_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, sclIn, sclOe, sdaIn, sdaOe, slewStdMode, byteIrq;
  logic        sclOut, sdaOut;
  logic [7:0]  rxB;
  logic        ackB;
  int          failures = 0, checkCount = 0, cycles = 0, irqs = 0;
  i2c_slave_stretch_buffer i2c_slave_stretch_buffer_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .ce(1'b1), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(sclIn),
    .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .slewStdMode(slewStdMode), .byteIrq(byteIrq));
  i2c_master_model i2c_master_model_i (.sclOe(sclOe), .sdaOe(sdaOe), .sclIn(sclIn),
    .sdaIn(sdaIn));
  // ****************************************
  // clock, timeout, interrupt count
  // ****************************************
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (byteIrq === 1'b1) irqs++;
    if (cycles == 40000) begin
      failures++;
      conclude();
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // ends on a falling edge so outputs have settled
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    psel   <= 1'b1;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge clk_sys);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    check(rd, e);
  endtask : rdChk
  task automatic bitChk(input int b, input logic e);
    apb(STAT_OFS, 1'b0, 32'h0);
    check(rd[b], e);
  endtask : bitChk
  task automatic xb(input logic [7:0] tx, input logic ao);
    i2c_master_model_i.xfer(tx, ao, rxB, ackB);
  endtask : xb
  // ****************************************
  // scenarios
  // ****************************************
  task automatic scReset();
    rdChk(CTRL_OFS, 32'h10);
    rdChk(PREF_OFS, 32'h0);
    apb(8'h40, 1'b0, 32'h0);
    check(err, 1'b1);
    check(slewStdMode, 1'b0);
  endtask : scReset
  task automatic scSpeed();
    wr(CTRL_OFS, 32'h12);
    check(slewStdMode, 1'b1);
    wr(CTRL_OFS, 32'h10);
    check(slewStdMode, 1'b0);
  endtask : scSpeed
  task automatic scOff();
    i2c_master_model_i.start();
    xb({ADDR_RST, 1'b0}, 1'b1);
    check(ackB, 1'b1);
    check(sclOe, 1'b0);
    i2c_master_model_i.stop();
    check(irqs, 0);
  endtask : scOff
  task automatic scHold();
    wr(CTRL_OFS, 32'h11);
    check(sclOe, 1'b1);
    check({sclOut, sdaOut}, 2'b00);
    wr(CTRL_OFS, 32'h15);
    check(sclOe, 1'b0);
  endtask : scHold
  task automatic scWrite();
    int n;
    n = irqs;
    i2c_master_model_i.start();
    xb({ADDR_RST, 1'b0}, 1'b1);
    check(ackB, 1'b0);
    xb(8'ha5, 1'b1);
    xb(8'h3c, 1'b1);
    i2c_master_model_i.stop();
    check(irqs - n, 3);
    bitChk(OVR_BIT, 1'b1);
    rdChk(DATA_OFS, 32'ha5);
    bitChk(BF_BIT, 1'b0);
    wr(STAT_OFS, 32'h1);
    wr(CTRL_OFS, 32'h1d);
    i2c_master_model_i.start();
    xb({ADDR_RST, 1'b0}, 1'b1);
    xb(8'h77, 1'b1);
    repeat (4) @(posedge clk_sys);
    check(sclOe, 1'b1);
    bitChk(OVR_BIT, 1'b0);
    rdChk(DATA_OFS, 32'h77);
    wr(CTRL_OFS, 32'h15);
    i2c_master_model_i.stop();
  endtask : scWrite
  task automatic scRead();
    i2c_master_model_i.start();
    xb({ADDR_RST, 1'b1}, 1'b1);
    repeat (4) @(posedge clk_sys);
    check(sclOe, 1'b1);
    bitChk(DIR_BIT, 1'b1);
    wr(DATA_OFS, 32'h96);
    rdChk(DATA_OFS, 32'h96);
    wr(CTRL_OFS, 32'h15);
    wr(DATA_OFS, 32'h00);
    rdChk(DATA_OFS, 32'h96);
    xb(8'hff, 1'b1);
    check(rxB, 8'h96);
    bitChk(DIR_BIT, 1'b0);
    wr(CTRL_OFS, 32'h15);
    i2c_master_model_i.stop();
    bitChk(WCOL_BIT, 1'b1);
    wr(STAT_OFS, 32'h2);
    bitChk(WCOL_BIT, 1'b0);
  endtask : scRead
  task automatic scPref();
    wr(CTRL_OFS, 32'h05);
    wr(PREF_OFS, 32'h5a);
    i2c_master_model_i.start();
    xb({ADDR_RST, 1'b1}, 1'b1);
    wr(PREF_OFS, 32'hc3);
    xb(8'hff, 1'b0);
    check(rxB, 8'h5a);
    xb(8'hff, 1'b1);
    check(rxB, 8'hc3);
    i2c_master_model_i.stop();
  endtask : scPref
  task automatic scModRst();
    wr(CTRL_OFS, 32'h25);
    rdChk(CTRL_OFS, 32'h30);
    rdChk(PREF_OFS, 32'h0);
    wr(CTRL_OFS, 32'h23);
    rdChk(CTRL_OFS, 32'h30);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdChk(CTRL_OFS, 32'h10);
  endtask : scModRst
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    scReset();
    scSpeed();
    scOff();
    scHold();
    scWrite();
    scRead();
    scPref();
    scModRst();
    conclude();
  end
endmodule : test_i2c_slave_stretch_buffer
